// ### verilog/rcp_defines.svh
`ifndef RCP_DEFINES_SVH
`define RCP_DEFINES_SVH

// channel numbering, zero based (line 1 is index 0)
`define RCP_NCH 8
`define RCP_CH_START_REQ 0
`define RCP_CH_STOP 1
`define RCP_CH_READY 2
`define RCP_CH_POWER_ON 3
`define RCP_CH_SPARE 4
`define RCP_CH_SHUTDOWN 5
`define RCP_CH_START 6
`define RCP_CH_PREPARE 7

// single-line data channel timing
`define RCP_CLK_NS 40
`define RCP_OW_RESET_US 480
`define RCP_OW_RESET_CYC ((`RCP_OW_RESET_US * 1000) / `RCP_CLK_NS)
`define RCP_OW_SLOT_US 60
`define RCP_OW_SLOT_CYC ((`RCP_OW_SLOT_US * 1000) / `RCP_CLK_NS)
`define RCP_OW_LOW1_US 6
`define RCP_OW_LOW1_CYC ((`RCP_OW_LOW1_US * 1000 + `RCP_CLK_NS - 1) / `RCP_CLK_NS)
`define RCP_OW_SAMPLE_US 15
`define RCP_OW_SAMPLE_CYC ((`RCP_OW_SAMPLE_US * 1000) / `RCP_CLK_NS)
`define RCP_OW_PRES_US 70
`define RCP_OW_PRES_CYC ((`RCP_OW_PRES_US * 1000) / `RCP_CLK_NS)
`define RCP_OW_RECOV_US 2
`define RCP_OW_RECOV_CYC ((`RCP_OW_RECOV_US * 1000 + `RCP_CLK_NS - 1) / `RCP_CLK_NS)
`define RCP_CNT_W 14

// supply fault filter
`define RCP_FLT_FILT_CYC 4

`endif

// ### verilog/rcp_pkg.sv
package rcp_pkg;
  typedef enum logic [2:0] {
    RCP_OW_IDLE = 3'b000,
    RCP_OW_RST_LOW = 3'b001,
    RCP_OW_RST_WAIT = 3'b010,
    RCP_OW_SLOT_LOW = 3'b011,
    RCP_OW_SLOT_REL = 3'b100,
    RCP_OW_RECOVER = 3'b101
  } rcp_ow_state_e;

  typedef enum logic [1:0] {
    RCP_OW_CMD_RESET = 2'b00,
    RCP_OW_CMD_WRITE = 2'b01,
    RCP_OW_CMD_READ = 2'b10
  } rcp_ow_cmd_e;
endpackage

// ### verilog/rcp_onewire.sv
`timescale 1ns/100ps
`include "rcp_defines.svh"

// single-line data master towards the add-on identification memory
module rcp_onewire
  import rcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [1:0] cmd_i,
  input wire logic wbit_i,
  output logic busy_o,
  output logic done_o,
  output logic rbit_o,
  input wire logic line_i,
  output logic line_oe_o
);
  rcp_ow_state_e state_q, state_d;
  logic [`RCP_CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic rbit_q, rbit_d;
  logic done_q, done_d;

  // timing walk; line_i is already synchronised by the parent
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + `RCP_CNT_W'(1);
    wr_d = wr_q;
    rd_d = rd_q;
    rbit_d = rbit_q;
    done_d = 1'b0;
    unique case (state_q)
      RCP_OW_IDLE: begin
        cnt_d = '0;
        if (req_i) begin
          wr_d = wbit_i;
          rd_d = (cmd_i == RCP_OW_CMD_READ);
          state_d = (cmd_i == RCP_OW_CMD_RESET) ? RCP_OW_RST_LOW : RCP_OW_SLOT_LOW;
          if (cmd_i == RCP_OW_CMD_READ) begin
            wr_d = 1'b1; // read slot is a write-one slot that samples
          end
        end
      end
      RCP_OW_RST_LOW: begin
        if (cnt_q == `RCP_CNT_W'(`RCP_OW_RESET_CYC - 1)) begin
          cnt_d = '0;
          state_d = RCP_OW_RST_WAIT;
        end
      end
      RCP_OW_RST_WAIT: begin
        // presence pulse from the add-on reads back as a zero
        if (cnt_q == `RCP_CNT_W'(`RCP_OW_PRES_CYC)) begin
          rbit_d = line_i;
        end
        if (cnt_q == `RCP_CNT_W'(`RCP_OW_RESET_CYC - 1)) begin
          cnt_d = '0;
          state_d = RCP_OW_RECOVER;
        end
      end
      RCP_OW_SLOT_LOW: begin
        if (wr_q && cnt_q == `RCP_CNT_W'(`RCP_OW_LOW1_CYC - 1)) begin
          state_d = RCP_OW_SLOT_REL;
        end else if (cnt_q == `RCP_CNT_W'(`RCP_OW_SLOT_CYC - 1)) begin
          state_d = RCP_OW_SLOT_REL;
        end
      end
      RCP_OW_SLOT_REL: begin
        if (rd_q && cnt_q == `RCP_CNT_W'(`RCP_OW_SAMPLE_CYC)) begin
          rbit_d = line_i;
        end
        if (cnt_q >= `RCP_CNT_W'(`RCP_OW_SLOT_CYC - 1)) begin
          cnt_d = '0;
          state_d = RCP_OW_RECOVER;
        end
      end
      RCP_OW_RECOVER: begin
        if (cnt_q == `RCP_CNT_W'(`RCP_OW_RECOV_CYC - 1)) begin
          state_d = RCP_OW_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = RCP_OW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= RCP_OW_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b1;
      rd_q <= 1'b0;
      rbit_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      rbit_q <= rbit_d;
      done_q <= done_d;
    end
  end

  // open-drain: only ever pull low
  assign line_oe_o = (state_q == RCP_OW_RST_LOW) || (state_q == RCP_OW_SLOT_LOW);
  assign busy_o = (state_q != RCP_OW_IDLE);
  assign done_o = done_q;
  assign rbit_o = rbit_q;
endmodule

// ### verilog/rcp_port.sv
`timescale 1ns/100ps
`include "rcp_defines.svh"

// Functional notes
// - low level means asserted, high deasserted; code decodes ready and power-on as high-true
// - lines only pulled low, wired-OR
// - start-request low starts injection cycle
// - stop low drives back to ready
// - ready high means system accepts analysis
// - power-on low flags a missing module
// - shutdown low stops risk-reducing activity
// - start low begins run or timetable
// - prepare low triggers pre-analysis setup
// - order ready, start, optional stop
// - eight channels, each input or output
// - single-line access to add-on memory
// - low-voltage supply on from reset
// - low-voltage short switches supply off
// - high-voltage supply only by command
// - overcurrent reported as status event
// - high-voltage short caught in hardware
module rcp_port
  import rcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  // remote coordination lines, open collector
  input wire logic [7:0] io_line_i,
  output logic [7:0] io_line_o,
  output logic [7:0] io_line_oe_o,
  // firmware-side channel control
  input wire logic [7:0] ch_out_en_i,
  input wire logic [7:0] ch_assert_i,
  output logic [7:0] ch_level_o,
  output logic [7:0] ch_fall_o,
  output logic [7:0] ch_rise_o,
  // decoded coordination events and states
  output logic start_req_o,
  output logic stop_o,
  output logic start_o,
  output logic prepare_o,
  output logic shutdown_o,
  output logic sys_ready_o,
  output logic all_powered_o,
  output logic run_active_o,
  output logic seq_error_o,
  // single-line data channel
  input wire logic ow_req_i,
  input wire logic [1:0] ow_cmd_i,
  input wire logic ow_wbit_i,
  output logic ow_busy_o,
  output logic ow_done_o,
  output logic ow_rbit_o,
  input wire logic ow_line_i,
  output logic ow_line_o,
  output logic ow_line_oe_o,
  // auxiliary supplies
  input wire logic aux5_restore_i,
  input wire logic aux5_short_i,
  input wire logic aux24_on_i,
  input wire logic aux24_off_i,
  input wire logic aux24_short_i,
  input wire logic aux24_overcur_i,
  output logic aux5_en_o,
  output logic aux24_en_o,
  output logic aux5_short_o,
  output logic aux24_short_o,
  output logic overcur_evt_o
);
  logic [1:0] rst_sync_q;
  logic rst_n;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // three-stage synchronisers; only stages 2 and 3 are compared
  logic [7:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic ow_s1_q, ow_s2_q, ow_s3_q, ow_lvl_q, ow_lvl_d;
  logic [2:0] flt_s1_q, flt_s2_q, flt_s3_q;
  logic [2:0] flt_lvl_q, flt_lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    ow_lvl_d = ow_lvl_q;
    flt_lvl_d = flt_lvl_q;
    // a change counts once stages two and three agree
    for (int i = 0; i < `RCP_NCH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
    if (ow_s2_q == ow_s3_q) begin
      ow_lvl_d = ow_s3_q;
    end
    for (int i = 0; i < 3; i++) begin
      if (flt_s2_q[i] == flt_s3_q[i]) begin
        flt_lvl_d[i] = flt_s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 8'hFF;
      s2_q <= 8'hFF;
      s3_q <= 8'hFF;
      lvl_q <= 8'hFF;
      ow_s1_q <= 1'b1;
      ow_s2_q <= 1'b1;
      ow_s3_q <= 1'b1;
      ow_lvl_q <= 1'b1;
      flt_s1_q <= 3'h0;
      flt_s2_q <= 3'h0;
      flt_s3_q <= 3'h0;
      flt_lvl_q <= 3'h0;
    end else begin
      s1_q <= io_line_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      ow_s1_q <= ow_line_i;
      ow_s2_q <= ow_s1_q;
      ow_s3_q <= ow_s2_q;
      ow_lvl_q <= ow_lvl_d;
      flt_s1_q <= {aux24_overcur_i, aux24_short_i, aux5_short_i};
      flt_s2_q <= flt_s1_q;
      flt_s3_q <= flt_s2_q;
      flt_lvl_q <= flt_lvl_d;
    end
  end

  // per-channel drivers and edge detection
  logic [7:0] prev_q;
  genvar g;
  generate
    for (g = 0; g < `RCP_NCH; g++) begin : g_ch
      // open collector: output value fixed low, only the enable moves
      assign io_line_o[g] = 1'b0;
      assign io_line_oe_o[g] = ch_out_en_i[g] & ch_assert_i[g];
      // logical level: high when the wire is low
      assign ch_level_o[g] = ~lvl_q[g];
      assign ch_fall_o[g] = prev_q[g] & ~lvl_q[g];
      assign ch_rise_o[g] = ~prev_q[g] & lvl_q[g];
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 8'hFF;
    end else begin
      prev_q <= lvl_q;
    end
  end

  // decoded coordination signals; spare channel is generic only
  assign start_req_o = ch_fall_o[`RCP_CH_START_REQ];
  assign stop_o = ~lvl_q[`RCP_CH_STOP];
  assign sys_ready_o = lvl_q[`RCP_CH_READY];
  assign all_powered_o = lvl_q[`RCP_CH_POWER_ON];
  assign shutdown_o = ~lvl_q[`RCP_CH_SHUTDOWN];
  assign start_o = ch_fall_o[`RCP_CH_START];
  assign prepare_o = ch_fall_o[`RCP_CH_PREPARE];

  // run tracking; stop or shutdown or lost power ends the run
  logic run_q, run_d, seqerr_q, seqerr_d;
  always_comb begin
    run_d = run_q;
    seqerr_d = 1'b0;
    if (start_o) begin
      if (sys_ready_o && all_powered_o && !shutdown_o) begin
        run_d = 1'b1;
      end else begin
        seqerr_d = 1'b1; // start without ready and power, or during shutdown
      end
    end
    if (stop_o || shutdown_o || !all_powered_o) begin
      run_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      seqerr_q <= 1'b0;
    end else begin
      run_q <= run_d;
      seqerr_q <= seqerr_d;
    end
  end
  assign run_active_o = run_q;
  assign seq_error_o = seqerr_q;

  // add-on memory channel
  rcp_onewire u_ow (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .req_i(ow_req_i),
    .cmd_i(ow_cmd_i),
    .wbit_i(ow_wbit_i),
    .busy_o(ow_busy_o),
    .done_o(ow_done_o),
    .rbit_o(ow_rbit_o),
    .line_i(ow_lvl_q),
    .line_oe_o(ow_line_oe_o)
  );
  assign ow_line_o = 1'b0;

  // supplies; short inputs are filtered so glitches do not trip
  logic aux5_q, aux5_d, aux24_q, aux24_d;
  logic s5_q, s5_d, s24_q, s24_d, oc_prev_q, oc_evt_q, oc_evt_d;
  logic [2:0] f5_cnt_q, f5_cnt_d, f24_cnt_q, f24_cnt_d;

  always_comb begin
    aux5_d = aux5_q;
    aux24_d = aux24_q;
    s5_d = s5_q;
    s24_d = s24_q;
    f5_cnt_d = flt_lvl_q[0] ? f5_cnt_q : 3'h0;
    f24_cnt_d = flt_lvl_q[1] ? f24_cnt_q : 3'h0;
    if (flt_lvl_q[0] && f5_cnt_q != 3'(`RCP_FLT_FILT_CYC)) begin
      f5_cnt_d = f5_cnt_q + 3'h1;
    end
    if (flt_lvl_q[1] && f24_cnt_q != 3'(`RCP_FLT_FILT_CYC)) begin
      f24_cnt_d = f24_cnt_q + 3'h1;
    end
    // restore only after the short clears; set wins over restore
    if (aux5_restore_i && !flt_lvl_q[0]) begin
      aux5_d = 1'b1;
      s5_d = 1'b0;
    end
    if (f5_cnt_q == 3'(`RCP_FLT_FILT_CYC)) begin
      aux5_d = 1'b0;
      s5_d = 1'b1;
    end
    if (aux24_on_i) begin
      aux24_d = 1'b1;
      s24_d = 1'b0;
    end
    if (aux24_off_i) begin
      aux24_d = 1'b0;
    end
    if (f24_cnt_q == 3'(`RCP_FLT_FILT_CYC)) begin
      aux24_d = 1'b0;
      s24_d = 1'b1;
    end
    oc_evt_d = flt_lvl_q[2] & ~oc_prev_q & aux24_q;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aux5_q <= 1'b1;
      aux24_q <= 1'b0;
      s5_q <= 1'b0;
      s24_q <= 1'b0;
      f5_cnt_q <= 3'h0;
      f24_cnt_q <= 3'h0;
      oc_prev_q <= 1'b0;
      oc_evt_q <= 1'b0;
    end else begin
      aux5_q <= aux5_d;
      aux24_q <= aux24_d;
      s5_q <= s5_d;
      s24_q <= s24_d;
      f5_cnt_q <= f5_cnt_d;
      f24_cnt_q <= f24_cnt_d;
      oc_prev_q <= flt_lvl_q[2];
      oc_evt_q <= oc_evt_d;
    end
  end
  assign aux5_en_o = aux5_q;
  assign aux24_en_o = aux24_q;
  assign aux5_short_o = s5_q;
  assign aux24_short_o = s24_q;
  assign overcur_evt_o = oc_evt_q;
endmodule

// ### tb/rcp_port_asserts.sv
`timescale 1ns/100ps
// port-level timing of the coordination port
module rcp_port_asserts
  import rcp_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] io_line_i,
  input wire logic [7:0] io_line_o,
  input wire logic [7:0] io_line_oe_o,
  input wire logic [7:0] ch_out_en_i,
  input wire logic [7:0] ch_assert_i,
  input wire logic [7:0] ch_level_o,
  input wire logic [7:0] ch_fall_o,
  input wire logic [7:0] ch_rise_o,
  input wire logic start_req_o,
  input wire logic stop_o,
  input wire logic start_o,
  input wire logic prepare_o,
  input wire logic shutdown_o,
  input wire logic sys_ready_o,
  input wire logic all_powered_o,
  input wire logic run_active_o,
  input wire logic seq_error_o,
  input wire logic ow_done_o,
  input wire logic ow_req_i,
  input wire logic [1:0] ow_cmd_i,
  input wire logic ow_wbit_i,
  input wire logic ow_busy_o,
  input wire logic ow_line_oe_o,
  input wire logic overcur_evt_o,
  input wire logic aux5_short_i,
  input wire logic aux24_short_i,
  input wire logic aux24_on_i,
  input wire logic aux24_off_i,
  input wire logic aux5_en_o,
  input wire logic aux24_en_o,
  input wire logic aux5_short_o,
  input wire logic aux24_short_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // levels held long enough to pass the synchroniser
  sequence s_stop_low; !io_line_i[1] [*6]; endsequence
  sequence s_faults; aux5_short_i && aux24_short_i [*8]; endsequence
  property p_oe; io_line_oe_o == (ch_out_en_i & ch_assert_i) && io_line_o == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("line drive wrong");
  property p_start; $fell(io_line_i[6]) |-> !start_o [*2] ##[1:3] start_o; endproperty
  a_start: assert property (p_start) else $error("start pulse late");
  property p_pulse;
    (start_o |=> !start_o) and (start_req_o |=> !start_req_o) and (prepare_o |=> !prepare_o)
      and (ow_done_o |=> !ow_done_o) and (overcur_evt_o |=> !overcur_evt_o);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_stop; s_stop_low |-> stop_o; endproperty
  a_stop: assert property (p_stop) else $error("stop level missed");
  property p_ready;
    (!io_line_i[2] [*6] |-> !sys_ready_o) and (!io_line_i[3] [*6] |-> !all_powered_o);
  endproperty
  a_ready: assert property (p_ready) else $error("ready level wrong");
  property p_shut; !io_line_i[5] [*6] |-> shutdown_o ##1 !run_active_o; endproperty
  a_shut: assert property (p_shut) else $error("shutdown ignored");
  property p_run_clr; stop_o |=> !run_active_o; endproperty
  a_run_clr: assert property (p_run_clr) else $error("run kept on stop");
  property p_seq; start_o && !sys_ready_o |-> ##[0:1] seq_error_o; endproperty
  a_seq: assert property (p_seq) else $error("no order error");
  property p_rst_sup; $rose(resetn_i) |-> aux5_en_o && !aux24_en_o; endproperty
  a_rst_sup: assert property (p_rst_sup) else $error("supply reset wrong");
  property p_24cmd;
    (aux24_off_i |=> !aux24_en_o) and (aux24_on_i && !aux24_off_i |=> aux24_en_o);
  endproperty
  a_24cmd: assert property (p_24cmd) else $error("24 V command ignored");
  property p_24rose; $rose(aux24_en_o) |-> $past(aux24_on_i); endproperty
  a_24rose: assert property (p_24rose) else $error("24 V on uncommanded");
  property p_short; s_faults |-> ##[0:2] !aux5_en_o && aux5_short_o && aux24_short_o; endproperty
  a_short: assert property (p_short) else $error("short not caught");
  // edge pulses stand in the same cycle in which the filtered level moves
  property p_edge;
    ch_fall_o == (ch_level_o & ~$past(ch_level_o))
      && ch_rise_o == (~ch_level_o & $past(ch_level_o));
  endproperty
  a_edge: assert property (p_edge) else $error("edge pulse wrong");
  // write slots taken in idle; a one releases early, a zero holds the line low
  sequence s_wr1_take;
    ow_req_i && !ow_busy_o && ow_cmd_i == RCP_OW_CMD_WRITE && ow_wbit_i;
  endsequence
  sequence s_wr0_take;
    ow_req_i && !ow_busy_o && ow_cmd_i == RCP_OW_CMD_WRITE && !ow_wbit_i;
  endsequence
  property p_ow1; s_wr1_take |=> ow_line_oe_o ##149 ow_line_oe_o ##1 !ow_line_oe_o; endproperty
  a_ow1: assert property (p_ow1) else $error("write one slot wrong");
  property p_ow0; s_wr0_take |=> ow_line_oe_o ##299 ow_line_oe_o; endproperty
  a_ow0: assert property (p_ow0) else $error("write zero slot short");
endmodule

bind rcp_port rcp_port_asserts u_chk (.clk_i, .resetn_i, .io_line_i, .io_line_o,
  .io_line_oe_o, .ch_out_en_i, .ch_assert_i, .ch_level_o, .ch_fall_o, .ch_rise_o,
  .ow_req_i, .ow_cmd_i, .ow_wbit_i, .ow_busy_o, .ow_line_oe_o,
  .start_req_o, .stop_o, .start_o, .prepare_o,
  .shutdown_o, .sys_ready_o, .all_powered_o, .run_active_o, .seq_error_o, .ow_done_o,
  .overcur_evt_o, .aux5_short_i, .aux24_short_i, .aux24_on_i, .aux24_off_i, .aux5_en_o,
  .aux24_en_o, .aux5_short_o, .aux24_short_o);

// ### tb/rcp_partner.sv
`timescale 1ns/100ps
// peer instruments on the shared lines plus an add-on id memory
module rcp_partner (
  input wire logic clk_i,
  input wire logic [7:0] io_oe_i,
  input wire logic [7:0] peer_pull_i,
  output logic [7:0] io_wire_o,
  input wire logic ow_oe_i,
  input wire logic rd_en_i,
  input wire logic rd_bit_i,
  output logic ow_wire_o
);
  logic pull = 1'b0;
  time t0;
  // pull-up shows only while nobody sinks the line
  assign io_wire_o = ~(io_oe_i | peer_pull_i);
  assign ow_wire_o = ~(ow_oe_i | pull);
  // presence after a long low; zero bits stretch read slots past the sample point
  always begin
    @(posedge ow_oe_i);
    t0 = $time;
    if (rd_en_i && !rd_bit_i) begin
      pull <= 1'b1;
      repeat (700) @(posedge clk_i);
      pull <= 1'b0;
    end else begin
      @(negedge ow_oe_i);
      if ($time - t0 > 200000) begin
        repeat (400) @(posedge clk_i);
        pull <= 1'b1;
        repeat (2500) @(posedge clk_i);
        pull <= 1'b0;
      end
    end
  end
endmodule

// ### tb/rcp_port_tb_top.sv
`timescale 1ns/100ps
module rcp_port_tb_top;
  import rcp_pkg::*;
  logic clk_i = 0, resetn_i = 0, ow_req_i = 0, ow_wbit_i = 0, ow_line_i, rd_en = 0, rd_bit = 0;
  logic [7:0] io_line_i, io_line_o, io_line_oe_o, ch_level_o, ch_fall_o, ch_rise_o;
  logic [7:0] ch_out_en_i = 0, ch_assert_i = 0, peer_pull = 0;
  logic [1:0] ow_cmd_i = 0;
  logic aux5_restore_i = 0, aux5_short_i = 0, aux24_on_i = 0, aux24_off_i = 0;
  logic aux24_short_i = 0, aux24_overcur_i = 0, saw_err = 0;
  logic start_req_o, stop_o, start_o, prepare_o, shutdown_o, sys_ready_o, all_powered_o;
  logic run_active_o, seq_error_o, ow_busy_o, ow_done_o, ow_rbit_o, ow_line_o, ow_line_oe_o;
  logic aux5_en_o, aux24_en_o, aux5_short_o, aux24_short_o, overcur_evt_o;
  logic [4:0] notes[$];
  int num_errors = 0, check_count = 0, seed = 75;

  rcp_port DUT (.clk_i, .resetn_i, .io_line_i, .io_line_o, .io_line_oe_o, .ch_out_en_i,
    .ch_assert_i, .ch_level_o, .ch_fall_o, .ch_rise_o, .start_req_o, .stop_o, .start_o,
    .prepare_o, .shutdown_o, .sys_ready_o, .all_powered_o, .run_active_o, .seq_error_o,
    .ow_req_i, .ow_cmd_i, .ow_wbit_i, .ow_busy_o, .ow_done_o, .ow_rbit_o, .ow_line_i,
    .ow_line_o, .ow_line_oe_o, .aux5_restore_i, .aux5_short_i, .aux24_on_i, .aux24_off_i,
    .aux24_short_i, .aux24_overcur_i, .aux5_en_o, .aux24_en_o, .aux5_short_o,
    .aux24_short_o, .overcur_evt_o);
  rcp_partner u_peer (.clk_i, .io_oe_i(io_line_oe_o), .peer_pull_i(peer_pull),
    .io_wire_o(io_line_i), .ow_oe_i(ow_line_oe_o), .rd_en_i(rd_en), .rd_bit_i(rd_bit),
    .ow_wire_o(ow_line_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one data-line transfer; rbit stands after done
  task automatic ow(input logic [1:0] c, input logic b, input logic exp_bit);
    notes.push_back(5'h10);
    ow_req_i <= 1'b1;
    ow_cmd_i <= c;
    ow_wbit_i <= b;
    tick(1);
    ow_req_i <= 1'b0;
    tick(1);
    check({ow_busy_o, ow_line_o}, 2'b10);
    for (int k = 0; k < 30000 && ow_done_o !== 1'b1; k++) tick(1);
    check(ow_done_o, 1'b1);
    tick(1);
    if (c != RCP_OW_CMD_WRITE) check(ow_rbit_o, exp_bit);
  endtask

  // event monitor: each pulse takes the oldest note
  always @(posedge clk_i) begin
    if (resetn_i && |{ow_done_o, overcur_evt_o, prepare_o, start_o, start_req_o}) begin
      if (notes.size() == 0) check(8'h00, 8'hFF);
      else check({ow_done_o, overcur_evt_o, prepare_o, start_o, start_req_o},
        notes.pop_front());
    end
    if (seq_error_o === 1'b1) saw_err <= 1'b1;
  end

  // watchdog well past the data-line resets
  initial begin
    tick(60000);
    num_errors++;
    final_report;
  end

  initial begin
    tick(20);
    resetn_i <= 1'b1;
    tick(4);
    check({aux5_en_o, aux24_en_o, ch_level_o[5:0]}, 8'h80);
    // a peer asserts each line in turn
    for (int i = 0; i < 8; i++) begin
      if (i == 0) notes.push_back(5'h01);
      if (i == 6) notes.push_back(5'h02);
      if (i == 7) notes.push_back(5'h04);
      peer_pull <= 8'h01 << i;
      tick(8);
      check(ch_level_o, 8'h01 << i);
      check({stop_o, sys_ready_o, all_powered_o, shutdown_o},
        {i == 1, i != 2, i != 3, i == 5});
      peer_pull <= 8'h00;
      tick(8);
    end
    check({saw_err, run_active_o}, 2'b01);
    peer_pull <= 8'h02;
    tick(8);
    check(run_active_o, 1'b0);
    peer_pull <= 8'h04;
    tick(8);
    notes.push_back(5'h02);
    peer_pull <= 8'h44;
    tick(8);
    check({saw_err, run_active_o}, 2'b10);
    peer_pull <= 8'h00;
    $display("test lines done");
    // the port drives the spare and stop channels itself, enables random
    repeat (4) begin
      ch_out_en_i <= 8'($random(seed)) & 8'h12;
      ch_assert_i <= 8'($random(seed));
      tick(8);
      check(io_line_oe_o | io_line_o, ch_assert_i & ch_out_en_i);
      check(ch_level_o, ch_assert_i & ch_out_en_i);
    end
    $display("test channels done");
    aux24_on_i <= 1'b1;
    tick(1);
    aux24_on_i <= 1'b0;
    tick(2);
    check(aux24_en_o, 1'b1);
    notes.push_back(5'h08);
    aux24_overcur_i <= 1'b1;
    tick(8);
    aux24_overcur_i <= 1'b0;
    aux24_off_i <= 1'b1;
    tick(1);
    aux24_off_i <= 1'b0;
    tick(2);
    check(aux24_en_o, 1'b0);
    aux5_short_i <= 1'b1;
    aux24_short_i <= 1'b1;
    tick(12);
    check({aux5_en_o, aux5_short_o, aux24_short_o}, 3'b011);
    aux5_short_i <= 1'b0;
    aux24_short_i <= 1'b0;
    tick(8);
    aux5_restore_i <= 1'b1;
    tick(1);
    aux5_restore_i <= 1'b0;
    tick(2);
    check({aux5_en_o, aux5_short_o}, 2'b10);
    $display("test supplies done");
    ow(RCP_OW_CMD_RESET, 1'b0, 1'b0);
    ow(RCP_OW_CMD_WRITE, 1'b1, 1'b0);
    ow(RCP_OW_CMD_WRITE, 1'b0, 1'b0);
    rd_en <= 1'b1;
    rd_bit <= 1'b1;
    ow(RCP_OW_CMD_READ, 1'($random(seed)), 1'b1);
    rd_bit <= 1'b0;
    ow(RCP_OW_CMD_READ, 1'($random(seed)), 1'b0);
    tick(4);
    check(8'(notes.size()), 8'h00);
    $display("test data line done");
    final_report;
  end
endmodule
